//--- dwc_host_model.sv
`timescale 1ns/1ps
`default_nettype none
module dwc_host_model (
   input  wire logic       clock,        // Device clock
   output logic            frame_start,  // Start condition
   output logic            frame_stop,   // Stop condition
   output logic            byte_valid,   // Byte strobe
   output logic      [7:0] byte_data,    // Byte value
   output logic            spi_mode      // SPI framing
);
   // Bus idle at time zero
   initial begin
      frame_start = 1'b0;
      frame_stop  = 1'b0;
      byte_valid  = 1'b0;
      byte_data   = 8'h00;
      spi_mode    = 1'b0;
   end

   // One frame; a new command always gets its own start
   task automatic send(input logic [7:0] cmd, input logic [7:0] d0,
                       input logic [7:0] d1, input logic two,
                       input logic spi);
      @(posedge clock);
      spi_mode    <= spi;
      frame_start <= 1'b1;
      @(posedge clock);
      frame_start <= 1'b0;
      byte_valid  <= 1'b1;
      byte_data   <= cmd;
      @(posedge clock);
      byte_data   <= d0;
      if (two) begin
         @(posedge clock);
         byte_data <= d1;
      end
      @(posedge clock);
      byte_valid  <= 1'b0;
      byte_data   <= ~byte_data; // Released bus shows no stale byte
      frame_stop  <= 1'b1;
      @(posedge clock);
      frame_stop  <= 1'b0;
   endtask
endmodule
`default_nettype wire

//--- dwc_pkg.sv
`default_nettype none
package dwc_pkg;
   // Channel count and code resolution
   localparam int unsigned CHANNELS  = 4;
   localparam int unsigned CODE_W    = 8;
   localparam int unsigned TAPS      = 256;
   localparam logic [7:0]  MIDSCALE  = 8'h80;

   // Command byte layout: code in [7:3], all-channels in [2], channel [1:0]
   localparam int unsigned CMD_CODE_LSB = 3;
   localparam int unsigned CMD_ALL_BIT  = 2;
   localparam logic [4:0] CMD_WR_WIPER = 5'h01;
   localparam logic [4:0] CMD_WR_INPUT = 5'h02;
   localparam logic [4:0] CMD_LOAD     = 5'h08;
   localparam logic [4:0] CMD_STORE    = 5'h09;
   localparam logic [4:0] CMD_RESET    = 5'h0E;
   localparam logic [4:0] CMD_SHUTDOWN = 5'h0F;
   localparam logic [4:0] CMD_CONTROL  = 5'h10;

   // Control register fields
   localparam int unsigned WIPER_UPDATE_ALLOW_BIT = 0;
   localparam int unsigned NVM_PROGRAM_ALLOW_BIT  = 1;
   localparam int unsigned GAIN_SETTING_SELECT_BIT = 2;
   localparam int unsigned MULTI_BYTE_WRITE_BIT   = 3;
   localparam logic [3:0]  CONTROL_RESET          = 4'h3;
   localparam logic [1:0]  ALLOW_BITS_RESET       = 2'h3;

   // Register port offsets
   localparam logic [3:0] REG_CONTROL    = 4'h0;
   localparam logic [3:0] REG_STATUS     = 4'h1;
   localparam logic [1:0] REG_WIPER_PAGE = 2'h1;
   localparam logic [1:0] REG_INPUT_PAGE = 2'h2;
   localparam logic [1:0] REG_NVM_PAGE   = 2'h3;

   // Reload timing
   localparam int unsigned CLOCK_PERIOD_NS = 10;
   localparam int unsigned RELOAD_TIME_NS  = 30000;
   localparam int unsigned RELOAD_CYCLES   =
      (RELOAD_TIME_NS + CLOCK_PERIOD_NS - 1) / CLOCK_PERIOD_NS;
   localparam logic [11:0] RELOAD_COUNT    = 12'(RELOAD_CYCLES - 1);

   typedef enum logic {
      DWC_IDLE,
      DWC_RELOAD
   } dwc_mode_t;

   typedef struct packed {
      dwc_mode_t       mode;
      logic [11:0]     timer;
      logic [3:0]      control;
      logic            shutdown;
      logic            wp_lock;
      logic            frame_open;
      logic            have_cmd;
      logic            data_seen;
      logic [7:0]      cmd_byte;
      logic [3:0][7:0] wiper;
      logic [3:0][7:0] input_reg;
      logic [3:0][7:0] nvm;
      logic [2:0]      rst_sync;
      logic [1:0]      wp_sync;
      logic [2:0]      ld_sync;
      logic [7:0]      rdata;
   } dwc_regs_t;
endpackage
`default_nettype wire

//--- dwc_wiper_control.sv
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Burst: later bytes are data for command
// - Control bit three enables burst mode, not for SPI frames
// - Reset by command 14 or pin
// - Reset reloads wipers from store, 30 us
// - Store holds midscale at power-up
// - Command 15 bit0=1 enters shutdown
// - Shutdown opens A or floats strings
// - Commands still run during shutdown
// - Command 15 bit0=0 leaves shutdown
// - Two allow bits guard wiper, store
// - Write-protect pin waits for command end
// - Protected wipers only take stored value
// - Input mirrors wiper; command 2 preloads
// - Command 8 loads one or all
// - Strobe pin loads all channels
// - Strobe ignored while command runs
// - Code selects one of 256 taps
// - Potentiometer A side complementary to code
// - Gain mode A side follows code
// - Allow bits freeze, reset to one
// - Wiper write overwrites input register
// - Reset returns to potentiometer mode
module dwc_wiper_control (
   input  wire logic         clock,            // 100 MHz clock
   input  wire logic         reset,            // Async power-on reset
   input  wire logic         frame_start,      // Start or repeated start
   input  wire logic         frame_stop,       // Stop condition
   input  wire logic         byte_valid,       // Received byte strobe
   input  wire logic [7:0]   byte_data,        // Received byte
   input  wire logic         spi_mode,         // Frame comes from SPI
   input  wire logic         reset_pin_n,      // Reset pin, async
   input  wire logic         write_protect_n,  // Protect pin, async
   input  wire logic         load_strobe_n,    // Wiper load strobe pin
   input  wire logic [3:0]   reg_addr,         // Register address
   input  wire logic [7:0]   reg_wdata,        // Register write data
   input  wire logic         reg_write,        // Write strobe
   input  wire logic         reg_read,         // Read strobe
   output logic      [7:0]   reg_rdata,        // Read data, next cycle
   output logic [3:0][255:0] wiper_tap,        // One-hot tap per channel
   output logic [3:0][7:0]   a_to_wiper_resistance, // A side code
   output logic [3:0][7:0]   wiper_to_b_resistance, // B side code
   output logic              a_switch_open,    // A terminal open
   output logic              wiper_to_b,       // Wiper tied to B
   output logic              a_string_hiz,     // A string floated
   output logic              b_string_hiz,     // B string floated
   output logic              reload_busy,      // Reload in progress
   output logic              shutdown_active   // Shutdown state
);

   dwc_pkg::dwc_regs_t r;
   dwc_pkg::dwc_regs_t n;

   logic       burst_on;
   logic       exec;
   logic       cmd_active;
   logic       wiper_prot;
   logic       nvm_prot;
   logic       hw_load;
   logic       pin_reset;
   logic       reload_done;
   logic       start_reload;
   logic [4:0] code;
   logic       all_ch;
   logic [1:0] ch;
   logic       gain_mode;

   // Decoded views of registered state
   assign code = r.cmd_byte[7:dwc_pkg::CMD_CODE_LSB];
   assign all_ch = r.cmd_byte[dwc_pkg::CMD_ALL_BIT];
   assign ch = r.cmd_byte[1:0];
   assign gain_mode = r.control[dwc_pkg::GAIN_SETTING_SELECT_BIT];
   assign burst_on = r.control[dwc_pkg::MULTI_BYTE_WRITE_BIT] &
                     ~spi_mode;
   // Frame open counts as a command in progress
   assign cmd_active = r.frame_open | (r.mode == dwc_pkg::DWC_RELOAD);
   assign wiper_prot = ~r.control[dwc_pkg::WIPER_UPDATE_ALLOW_BIT] |
                       r.wp_lock;
   assign nvm_prot = ~r.control[dwc_pkg::NVM_PROGRAM_ALLOW_BIT] |
                     r.wp_lock;
   // Edges taken from second and third stages only
   assign pin_reset = r.rst_sync[2] & ~r.rst_sync[1];
   assign hw_load = r.ld_sync[2] & ~r.ld_sync[1] & ~cmd_active;
   assign reload_done = (r.mode == dwc_pkg::DWC_RELOAD) &&
                        (r.timer == 12'h000);
   // First data byte runs when not reloading; later ones only in burst
   assign exec = byte_valid & r.frame_open & r.have_cmd & ~frame_start &
                 ~frame_stop & (~r.data_seen | burst_on) &
                 (r.mode == dwc_pkg::DWC_IDLE);
   assign start_reload = (pin_reset |
                          (exec && code == dwc_pkg::CMD_RESET)) &&
                         (r.mode == dwc_pkg::DWC_IDLE);

   // Next-state logic for the whole block
   always_comb begin
      n = r;
      n.rst_sync = {r.rst_sync[1:0], reset_pin_n};
      n.wp_sync = {r.wp_sync[0], write_protect_n};
      n.ld_sync = {r.ld_sync[1:0], load_strobe_n};
      // Protect pin latched only between commands
      if (!cmd_active) begin
         n.wp_lock = ~r.wp_sync[1];
      end
      // Framing: a restart drops the old command
      if (frame_start) begin
         n.frame_open = 1'b1;
         n.have_cmd = 1'b0;
         n.data_seen = 1'b0;
      end else if (frame_stop) begin
         n.frame_open = 1'b0;
         n.have_cmd = 1'b0;
         n.data_seen = 1'b0;
      end else if (byte_valid && r.frame_open) begin
         if (!r.have_cmd) begin
            n.cmd_byte = byte_data;
            n.have_cmd = 1'b1;
         end else begin
            n.data_seen = 1'b1;
         end
      end
      // Register port write steers the control bits
      if (reg_write && reg_addr == dwc_pkg::REG_CONTROL) begin
         n.control = reg_wdata[3:0];
      end
      // Command execution
      if (exec) begin
         unique case (code)
            dwc_pkg::CMD_WR_WIPER: begin
               if (!wiper_prot) begin
                  n.wiper[ch] = byte_data;
                  n.input_reg[ch] = byte_data;
               end
            end
            dwc_pkg::CMD_WR_INPUT: begin
               n.input_reg[ch] = byte_data;
            end
            dwc_pkg::CMD_LOAD: begin
               for (int i = 0; i < 4; i++) begin
                  if (!wiper_prot && (all_ch || ch == 2'(i))) begin
                     n.wiper[i] = r.input_reg[i];
                  end
               end
            end
            dwc_pkg::CMD_STORE: begin
               for (int i = 0; i < 4; i++) begin
                  if (!nvm_prot && (all_ch || ch == 2'(i))) begin
                     n.nvm[i] = r.wiper[i];
                  end
               end
            end
            dwc_pkg::CMD_RESET: begin
               n.shutdown = r.shutdown; // Handled by reload start
            end
            dwc_pkg::CMD_SHUTDOWN: begin
               n.shutdown = byte_data[0];
            end
            dwc_pkg::CMD_CONTROL: begin
               n.control = byte_data[3:0];
            end
            default: begin
               n.shutdown = r.shutdown; // Undefined codes do nothing
            end
         endcase
      end
      // Strobe pin copies every preload into its wiper
      if (hw_load && !wiper_prot) begin
         n.wiper = r.input_reg;
      end
      // Reload sequence from nonvolatile store
      unique case (r.mode)
         dwc_pkg::DWC_IDLE: begin
            if (start_reload) begin
               n.mode = dwc_pkg::DWC_RELOAD;
               n.timer = dwc_pkg::RELOAD_COUNT;
            end
         end
         dwc_pkg::DWC_RELOAD: begin
            if (reload_done) begin
               n.mode = dwc_pkg::DWC_IDLE;
               n.wiper = r.nvm;
               n.input_reg = r.nvm;
               n.control[dwc_pkg::GAIN_SETTING_SELECT_BIT] = 1'b0;
               n.control[1:0] = dwc_pkg::ALLOW_BITS_RESET;
            end else begin
               n.timer = r.timer - 12'h001;
            end
         end
      endcase
      // Read data stands only in the cycle after the strobe
      n.rdata = 8'h00;
      if (reg_read) begin
         unique case (reg_addr[3:2])
            2'h0: begin
               if (reg_addr == dwc_pkg::REG_CONTROL) begin
                  n.rdata = {4'h0, r.control};
               end else if (reg_addr == dwc_pkg::REG_STATUS) begin
                  n.rdata = {4'h0, r.wp_lock, r.frame_open, r.shutdown,
                             r.mode == dwc_pkg::DWC_RELOAD};
               end
            end
            dwc_pkg::REG_WIPER_PAGE: n.rdata = r.wiper[reg_addr[1:0]];
            dwc_pkg::REG_INPUT_PAGE: n.rdata = r.input_reg[reg_addr[1:0]];
            dwc_pkg::REG_NVM_PAGE:   n.rdata = r.nvm[reg_addr[1:0]];
         endcase
      end
   end

   // State register; store comes up at midscale
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         r <= '0;
         r.control <= dwc_pkg::CONTROL_RESET;
         r.wiper <= {4{dwc_pkg::MIDSCALE}};
         r.input_reg <= {4{dwc_pkg::MIDSCALE}};
         r.nvm <= {4{dwc_pkg::MIDSCALE}};
         r.rst_sync <= 3'h7;
         r.wp_sync <= 2'h3;
         r.ld_sync <= 3'h7;
      end else begin
         r <= n;
      end
   end

   // Tap decode and resistance codes per channel
   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_chan
         assign wiper_tap[g] = 256'h1 << r.wiper[g];
         assign wiper_to_b_resistance[g] = r.wiper[g];
         // Gain mode drives the A string straight from the code
         assign a_to_wiper_resistance[g] =
            gain_mode ? r.wiper[g] : ~r.wiper[g];
      end
   endgenerate

   // Shutdown switch controls; wiper codes stay untouched
   assign a_switch_open = r.shutdown & ~gain_mode;
   assign wiper_to_b = r.shutdown & ~gain_mode;
   assign a_string_hiz = r.shutdown;
   assign b_string_hiz = r.shutdown & gain_mode;
   assign reload_busy = (r.mode == dwc_pkg::DWC_RELOAD);
   assign shutdown_active = r.shutdown;
   assign reg_rdata = r.rdata;

   // Checks
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (reset);

   sequence reload_enter;
      r.mode == dwc_pkg::DWC_IDLE ##1 r.mode == dwc_pkg::DWC_RELOAD;
   endsequence

   sequence reload_finish;
      reload_done;
   endsequence

   reload_length_a: assert property (
      reload_enter |-> (r.timer == dwc_pkg::RELOAD_COUNT) and
      (r.mode == dwc_pkg::DWC_RELOAD) [*8])
      else $error("reload ended too early");

   reload_copy_a: assert property (
      reload_finish |=> (r.wiper == $past(r.nvm)) && !gain_mode &&
      (r.control[1:0] == dwc_pkg::ALLOW_BITS_RESET))
      else $error("reload did not restore wipers");

   pin_reset_a: assert property (
      (pin_reset && r.mode == dwc_pkg::DWC_IDLE) |=>
      r.mode == dwc_pkg::DWC_RELOAD)
      else $error("reset pin did not start reload");

   shutdown_set_a: assert property (
      (exec && code == dwc_pkg::CMD_SHUTDOWN) |=>
      (r.shutdown == $past(byte_data[0])) && $stable(r.wiper))
      else $error("shutdown command misbehaved");

   protect_hold_a: assert property (
      (wiper_prot && !reload_done) |=> $stable(r.wiper))
      else $error("protected wiper changed");

   mirror_input_a: assert property (
      (!$stable(r.wiper) && !$past(hw_load)) |-> r.input_reg == r.wiper)
      else $error("input register not mirrored");

   strobe_ignore_a: assert property (
      ($past(r.ld_sync[2]) && !$past(r.ld_sync[1]) && $past(cmd_active) &&
       !$past(exec) && !$past(reload_done)) |-> $stable(r.wiper))
      else $error("strobe acted during command");

   burst_gate_a: assert property (
      exec |-> (!r.data_seen ||
      (r.control[dwc_pkg::MULTI_BYTE_WRITE_BIT] && !spi_mode)))
      else $error("extra byte executed without burst");

   tap_onehot_a: assert property (
      $onehot(wiper_tap[0]) && wiper_tap[0][r.wiper[0]])
      else $error("tap decode not one-hot");

   pot_complement_a: assert property (
      !gain_mode |-> (9'(a_to_wiper_resistance[1]) +
      9'(r.wiper[1]) == 9'h0FF))
      else $error("A side not complementary");

   wp_defer_a: assert property (
      cmd_active |=> $stable(r.wp_lock))
      else $error("protect changed mid command");

endmodule
`default_nettype wire

//--- dwc_wiper_control_tb.sv
`timescale 1ns/1ps
`default_nettype none
module dwc_wiper_control_tb;
   logic                 clock = 1'b0;
   logic                 reset = 1'b1;
   logic                 write_protect_n = 1'b1;
   logic                 load_strobe_n = 1'b1;
   logic                 reset_pin_n = 1'b1;
   logic [3:0]           reg_addr = 4'h0;
   logic [7:0]           reg_wdata = 8'h00;
   logic                 reg_write = 1'b0;
   logic                 reg_read = 1'b0;
   logic                 frame_start, frame_stop, byte_valid, spi_mode;
   logic [7:0]           byte_data, reg_rdata;
   logic [3:0][255:0]    wiper_tap;
   logic [3:0][7:0]      a_res, b_res;
   logic                 a_open, w_to_b, a_hiz, b_hiz, busy, sd;
   int                   errors = 0;
   int                   n_compared = 0;

   // 100 MHz clock
   always #5 clock = ~clock;

   dwc_host_model host (.clock(clock), .frame_start(frame_start),
      .frame_stop(frame_stop), .byte_valid(byte_valid),
      .byte_data(byte_data), .spi_mode(spi_mode));

   // Reset pin driven so both reload paths are exercised
   dwc_wiper_control dut (.clock(clock), .reset(reset),
      .frame_start(frame_start), .frame_stop(frame_stop),
      .byte_valid(byte_valid), .byte_data(byte_data), .spi_mode(spi_mode),
      .reset_pin_n(reset_pin_n), .write_protect_n(write_protect_n),
      .load_strobe_n(load_strobe_n), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
      .reg_rdata(reg_rdata), .wiper_tap(wiper_tap),
      .a_to_wiper_resistance(a_res), .wiper_to_b_resistance(b_res),
      .a_switch_open(a_open), .wiper_to_b(w_to_b), .a_string_hiz(a_hiz),
      .b_string_hiz(b_hiz), .reload_busy(busy), .shutdown_active(sd));

   task automatic final_report;
      if (errors == 0 && n_compared > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic reg_rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge clock);
      reg_read <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_read <= 1'b0;
      #1 v = reg_rdata;
   endtask

   task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_write <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_write <= 1'b0;
   endtask

   task automatic chk_reg(input logic [3:0] a, input logic [7:0] e);
      logic [7:0] v;
      reg_rd(a, v);
      chk(v, e);
   endtask

   task automatic cmd(input logic [7:0] c, input logic [7:0] d);
      host.send(c, d, 8'h00, 1'b0, 1'b0);
   endtask

   // Pins pass two sync flops and an edge flop before acting
   task automatic pin_wait;
      repeat (6) @(posedge clock);
   endtask

   task automatic t_power_up;
      chk_reg(4'h4, 8'h80);
      chk_reg(4'hF, 8'h80);
      chk_reg(4'h0, 8'h03);
   endtask

   task automatic t_write_decode;
      cmd(8'h08, 8'h55);
      chk_reg(4'h4, 8'h55);
      chk_reg(4'h8, 8'h55);
      chk({7'h00, wiper_tap[0][8'h55]}, 8'h01);
      chk(a_res[0], 8'hAA);
   endtask

   task automatic t_preload;
      cmd(8'h11, 8'h22);
      chk_reg(4'h5, 8'h80);
      cmd(8'h44, 8'h00);
      chk_reg(4'h5, 8'h22);
      chk_reg(4'h4, 8'h55);
   endtask

   task automatic t_burst;
      reg_wr(4'h0, 8'h0B);
      reg_wr(4'h5, 8'hEE);
      host.send(8'h0A, 8'h11, 8'h33, 1'b1, 1'b0);
      chk_reg(4'h6, 8'h33);
      host.send(8'h0A, 8'h44, 8'h66, 1'b1, 1'b1);
      chk_reg(4'h6, 8'h44);
      chk_reg(4'h5, 8'h22);
      reg_wr(4'h0, 8'h03);
   endtask

   task automatic t_shutdown;
      cmd(8'h78, 8'h01);
      chk({4'h0, sd, a_open, w_to_b, a_hiz}, 8'h0F);
      chk_reg(4'h4, 8'h55);
      cmd(8'h08, 8'h5A);
      chk_reg(4'h4, 8'h5A);
      reg_wr(4'h0, 8'h07);
      #1 chk({6'h00, b_hiz, a_open}, 8'h02);
      chk(a_res[0], 8'h5A);
      reg_wr(4'h0, 8'h03);
      cmd(8'h78, 8'h00);
      chk({7'h00, sd}, 8'h00);
   endtask

   task automatic t_protect;
      cmd(8'h80, 8'h02);
      cmd(8'h08, 8'h99);
      chk_reg(4'h4, 8'h5A);
      cmd(8'h80, 8'h03);
      @(posedge clock);
      write_protect_n <= 1'b0;
      pin_wait();
      cmd(8'h08, 8'h77);
      chk_reg(4'h4, 8'h5A);
      write_protect_n <= 1'b1;
      pin_wait();
      cmd(8'h08, 8'h77);
      chk_reg(4'h4, 8'h77);
      cmd(8'h13, 8'h3C);
      load_strobe_n <= 1'b0;
      pin_wait();
      load_strobe_n <= 1'b1;
      chk_reg(4'h7, 8'h3C);
   endtask

   // Bounded wait for the reload to finish
   task automatic wait_reload;
      int k;
      for (k = 0; k < 4000 && busy === 1'b1; k++) begin
         @(posedge clock);
      end
      if (k == 4000) begin
         errors++;
         final_report();
      end
   endtask

   // Store all, then disturb wiper and control before reload
   task automatic t_soft_reset;
      cmd(8'h4C, 8'h00);
      chk_reg(4'hC, 8'h77);
      chk_reg(4'hF, 8'h3C);
      cmd(8'h08, 8'h11);
      reg_wr(4'h0, 8'h04);
      cmd(8'h70, 8'h00);
      chk({7'h00, busy}, 8'h01);
      wait_reload();
      chk_reg(4'h4, 8'h77);
      chk_reg(4'h8, 8'h77);
      chk_reg(4'h7, 8'h3C);
      chk_reg(4'h0, 8'h03);
   endtask

   // Pin pulse must reload the stored codes too
   task automatic t_pin_reset;
      cmd(8'h08, 8'h21);
      chk_reg(4'h4, 8'h21);
      @(posedge clock);
      reset_pin_n <= 1'b0;
      pin_wait();
      reset_pin_n <= 1'b1;
      chk({7'h00, busy}, 8'h01);
      wait_reload();
      chk_reg(4'h4, 8'h77);
   endtask

   // Main sequence
   initial begin
      repeat (10) @(posedge clock);
      reset <= 1'b0;
      t_power_up();
      t_write_decode();
      t_preload();
      t_burst();
      t_shutdown();
      t_protect();
      t_soft_reset();
      t_pin_reset();
      final_report();
   end
endmodule
`default_nettype wire
